// *** verilog/uls_pkg.sv ***
// Shared constants and helper functions for the serial port status block.
package uls_pkg;
  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] ADDR_DATA = 32'hE001_0000;
  localparam logic [31:0] ADDR_DIV_HIGH = 32'hE001_0004;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'hE001_0008;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'hE001_000C;
  localparam logic [31:0] ADDR_MODEM_CTRL = 32'hE001_0010;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'hE001_0014;
  localparam logic [31:0] ADDR_MODEM_STATUS = 32'hE001_0018;
  localparam logic [31:0] ADDR_SCRATCH = 32'hE001_001C;

  // ==========================================================================
  // Field positions.
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_BREAK = 6;
  localparam int LCR_DLAB = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_RST = 1;
  localparam int FCR_TX_RST = 2;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_LOOP = 4;

  // ==========================================================================
  // Reset values and timing.
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] DLL_RESET = 8'h01;
  localparam logic [7:0] DLM_RESET = 8'h00;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [4:0] MCR_RESET = 5'h00;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [2:0] MIN_LAST_BIT = 3'h4;

  // ==========================================================================
  // Helpers.
  function automatic logic [7:0] uls_mask(input logic [1:0] wl);
    return 8'hFF >> (2'h3 - wl);
  endfunction

  function automatic logic uls_par_bit(input logic [7:0] d, input logic [1:0] wl, input logic [1:0] sel);
    logic p;
    p = ^(d & uls_mask(wl));
    case (sel)
      2'h0: return ~p;
      2'h1: return p;
      2'h2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// *** verilog/uls_rx_if.sv ***
// Link between the register side and the receiver shifter.
`timescale 1ns/10ps
interface uls_rx_if;
  logic tick;
  logic sin;
  logic [1:0] word_len;
  logic par_en;
  logic [1:0] par_sel;
  logic done;
  logic [7:0] data;
  logic par_err;
  logic frame_err;
  logic brk;
  modport ctrl(output tick, sin, word_len, par_en, par_sel, input done, data, par_err, frame_err, brk);
  modport rx(input tick, sin, word_len, par_en, par_sel, output done, data, par_err, frame_err, brk);
endinterface

// *** verilog/uls_receiver.sv ***
// Receive shifter: assembles characters and reports their errors.
`timescale 1ns/10ps
module uls_receiver (
  input wire logic clk_sys, // System clock.
  input wire logic reset,   // Asynchronous reset, active high.
  uls_rx_if.rx link         // Oversample tick, serial level and results.
);
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100,
    RX_BRK = 3'b101
  } uls_rx_state_t;

  typedef struct packed {
    uls_rx_state_t st;
    logic [3:0] cnt;
    logic [2:0] idx;
    logic [7:0] shift;
    logic zeros;
    logic par;
    logic done;
    logic [7:0] data;
    logic pe;
    logic fe;
    logic brk;
  } uls_rx_t;

  uls_rx_t s_ff;
  uls_rx_t nxt_s;

  // ==========================================================================
  // Character assembly.
  always_comb begin
    logic [7:0] rxd;
    rxd = s_ff.shift >> (2'h3 - link.word_len);
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (link.tick) begin
      nxt_s.cnt = s_ff.cnt + 4'h1;
      case (s_ff.st)
        RX_IDLE: begin
          nxt_s.cnt = 4'h0;
          if (!link.sin) begin
            nxt_s.st = RX_START;
          end
        end
        RX_START: begin
          if (s_ff.cnt == uls_pkg::SAMPLE_MID) begin
            nxt_s.cnt = 4'h0;
            nxt_s.idx = 3'h0;
            nxt_s.zeros = 1'b1;
            nxt_s.st = link.sin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_ff.cnt == uls_pkg::TICK_LAST) begin
            nxt_s.cnt = 4'h0;
            nxt_s.shift = {link.sin, s_ff.shift[7:1]};
            nxt_s.zeros = s_ff.zeros & ~link.sin;
            nxt_s.idx = s_ff.idx + 3'h1;
            if (s_ff.idx == uls_pkg::MIN_LAST_BIT + {1'b0, link.word_len}) begin
              nxt_s.st = link.par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_ff.cnt == uls_pkg::TICK_LAST) begin
            nxt_s.cnt = 4'h0;
            nxt_s.par = link.sin;
            nxt_s.zeros = s_ff.zeros & ~link.sin;
            nxt_s.st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_ff.cnt == uls_pkg::TICK_LAST) begin
            nxt_s.cnt = 4'h0;
            nxt_s.done = 1'b1;
            nxt_s.data = rxd;
            nxt_s.brk = s_ff.zeros & ~link.sin;
            nxt_s.fe = ~link.sin;
            nxt_s.pe = link.par_en & (s_ff.par != uls_pkg::uls_par_bit(rxd, link.word_len, link.par_sel));
            if (s_ff.zeros && !link.sin) begin
              nxt_s.st = RX_BRK;
            end else if (!link.sin) begin
              // The low stop bit stands in for a start bit already sampled.
              nxt_s.st = RX_DATA;
              nxt_s.idx = 3'h0;
              nxt_s.zeros = 1'b1;
            end else begin
              nxt_s.st = RX_IDLE;
            end
          end
        end
        RX_BRK: begin
          if (link.sin) begin
            nxt_s.st = RX_IDLE;
          end
        end
        default: begin
          nxt_s.st = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.done = s_ff.done;
  assign link.data = s_ff.data;
  assign link.par_err = s_ff.pe;
  assign link.frame_err = s_ff.fe;
  assign link.brk = s_ff.brk;
endmodule

// *** verilog/uls_uart_status.sv ***
// Serial port with line status, modem status, scratch byte and datapath.
// What this block does
// - Receive ready while receive buffer holds data.
// - Full FIFO: set overrun, drop new character.
// - Flag parity error; status read clears it.
// - Flag low stop bit; status read clears.
// - After framing error, bad stop starts next.
// - Flag break after full low character time.
// - After break, wait idle until line high.
// - Error flag timing follows FIFO enable bit.
// - Holding empty sets on empty, clears on write.
// - Transmitter empty only when holding and shifter empty.
// - FIFO error flag; read clears when none remain.
// - Modem delta bits set on change, clear on read.
// - Ring trailing edge on rising ring input.
// - Modem state bits show inverted input pins.
// - Loopback drives modem state from control bits.
// - Modem inputs never affect serial transfer.
// - Free scratch byte, reset zero, no side effects.
// - Receiver shifts characters into receive FIFO.
// - Transmitter drains holding FIFO through shifter.
// - Divisor latches make sixteen-times oversample enable.
// - Events go out as one-cycle pulses.
// - Loopback joins transmit to receive, pin marks.
`timescale 1ns/10ps
module uls_uart_status #(
  parameter int FIFO_DEPTH = 16 // Entries per FIFO, a power of two.
) (
  input wire logic clk_sys,          // System clock, 100 MHz.
  input wire logic reset,            // Asynchronous reset, active high.
  input wire logic bus_req,          // One-cycle access strobe.
  input wire logic bus_write,        // High for write, low for read.
  input wire logic [31:0] bus_addr,  // Byte address.
  input wire logic [7:0] bus_wdata,  // Write data.
  output logic [7:0] bus_rdata,      // Read data, one cycle after request.
  output logic bus_ack,              // Access done pulse.
  input wire logic serial_in_pin,    // Serial receive line.
  output logic serial_out_pin,       // Serial transmit line.
  input wire logic cts_n_pin,        // Clear to send, active low.
  input wire logic dsr_n_pin,        // Data set ready, active low.
  input wire logic ri_n_pin,         // Ring indicator, active low.
  input wire logic dcd_n_pin,        // Carrier detect, active low.
  output logic dtr_n_pin,            // Data terminal ready, active low.
  output logic rts_n_pin,            // Request to send, active low.
  output logic rx_event_pulse,       // Character received.
  output logic tx_event_pulse,       // Holding FIFO became empty.
  output logic modem_event_pulse     // Modem delta bit set.
);
  localparam int AW = $clog2(FIFO_DEPTH);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } uls_tx_state_t;

  typedef struct packed {
    logic [2:0] sin_sync;
    logic sin_f;
    logic [3:0] msy1;
    logic [3:0] msy2;
    logic [3:0] msy3;
    logic [3:0] mpin;
    logic [3:0] mst;
    logic [3:0] mdelta;
    logic [7:0] lcr;
    logic fcr_en;
    logic [4:0] mcr;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [7:0] scr;
    logic [15:0] bcnt;
    logic tick;
    logic [FIFO_DEPTH-1:0][10:0] rxm;
    logic [AW-1:0] rxw;
    logic [AW-1:0] rxr;
    logic [AW:0] rxc;
    logic [AW:0] rxe;
    logic [FIFO_DEPTH-1:0][7:0] txm;
    logic [AW-1:0] txw;
    logic [AW-1:0] txr;
    logic [AW:0] txc;
    uls_tx_state_t tst;
    logic [3:0] tcnt;
    logic [2:0] tidx;
    logic [7:0] tsh;
    logic tpar;
    logic tout;
    logic sout;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic rx_fifo_error_flag;
    logic [7:0] rdata;
    logic ack;
    logic rxev;
    logic txev;
    logic mev;
  } uls_state_t;

  uls_state_t s_ff;
  uls_state_t nxt_s;
  uls_rx_if rxl();

  uls_receiver u_rx (
    .clk_sys(clk_sys),
    .reset(reset),
    .link(rxl)
  );

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    logic loop;
    logic dlab;
    logic rd;
    logic wr;
    logic [AW:0] cap;
    logic [3:0] mcur;
    logic [15:0] div;
    logic pop;
    logic push;
    logic rx_err;
    logic tx_push;
    logic tx_pop;
    logic head_new;
    logic [10:0] head;
    logic [7:0] rx_head;
    loop = s_ff.mcr[uls_pkg::MCR_LOOP];
    dlab = s_ff.lcr[uls_pkg::LCR_DLAB];
    rd = bus_req & ~bus_write;
    wr = bus_req & bus_write;
    cap = s_ff.fcr_en ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);
    div = {s_ff.dlm, s_ff.dll};
    rx_head = s_ff.rxm[s_ff.rxr][7:0];
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    nxt_s.ack = bus_req;
    nxt_s.rxev = 1'b0;
    nxt_s.mev = 1'b0;

    // Three-stage input filters; a level counts once stages two and three agree.
    nxt_s.sin_sync = {s_ff.sin_sync[1:0], serial_in_pin};
    if (s_ff.sin_sync[1] == s_ff.sin_sync[2]) begin
      nxt_s.sin_f = s_ff.sin_sync[2];
    end
    nxt_s.msy1 = {dcd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
    nxt_s.msy2 = s_ff.msy1;
    nxt_s.msy3 = s_ff.msy2;
    nxt_s.mpin = (s_ff.msy2 & s_ff.msy3) | (s_ff.mpin & (s_ff.msy2 ^ s_ff.msy3));

    // Modem state: bit 0 clear to send, 1 data set ready, 2 ring, 3 carrier.
    if (loop) begin
      mcur = {s_ff.mcr[3], s_ff.mcr[2], s_ff.mcr[0], s_ff.mcr[1]};
    end else begin
      mcur = ~s_ff.mpin;
    end
    nxt_s.mst = mcur;
    if (rd && bus_addr == uls_pkg::ADDR_MODEM_STATUS) begin
      nxt_s.mdelta = 4'h0;
    end
    nxt_s.mdelta[0] = nxt_s.mdelta[0] | (mcur[0] ^ s_ff.mst[0]);
    nxt_s.mdelta[1] = nxt_s.mdelta[1] | (mcur[1] ^ s_ff.mst[1]);
    nxt_s.mdelta[2] = nxt_s.mdelta[2] | (s_ff.mst[2] & ~mcur[2]);
    nxt_s.mdelta[3] = nxt_s.mdelta[3] | (mcur[3] ^ s_ff.mst[3]);
    nxt_s.mev = |((mcur ^ s_ff.mst) & 4'hB) | (s_ff.mst[2] & ~mcur[2]);

    // Oversample enable; a zero divisor halts it.
    if (div != 16'h0000) begin
      if (s_ff.bcnt >= div - 16'h0001) begin
        nxt_s.bcnt = 16'h0000;
        nxt_s.tick = 1'b1;
      end else begin
        nxt_s.bcnt = s_ff.bcnt + 16'h0001;
      end
    end

    // Register reads show the flags as they stand before any clear.
    if (rd) begin
      case (bus_addr)
        uls_pkg::ADDR_DATA: nxt_s.rdata = dlab ? s_ff.dll : (s_ff.rxc != '0 ? rx_head : 8'h00);
        uls_pkg::ADDR_DIV_HIGH: nxt_s.rdata = dlab ? s_ff.dlm : 8'h00;
        uls_pkg::ADDR_LINE_CTRL: nxt_s.rdata = s_ff.lcr;
        uls_pkg::ADDR_MODEM_CTRL: nxt_s.rdata = {3'h0, s_ff.mcr[4:2], loop ? 2'h0 : s_ff.mcr[1:0]};
        uls_pkg::ADDR_LINE_STATUS: begin
          nxt_s.rdata = {s_ff.rx_fifo_error_flag, (s_ff.txc == '0) && (s_ff.tst == TX_IDLE),
                         s_ff.txc == '0, s_ff.bi, s_ff.fe, s_ff.pe, s_ff.oe,
                         s_ff.rxc != '0};
          nxt_s.oe = 1'b0;
          nxt_s.pe = 1'b0;
          nxt_s.fe = 1'b0;
          nxt_s.bi = 1'b0;
        end
        uls_pkg::ADDR_MODEM_STATUS: nxt_s.rdata = {s_ff.mst, s_ff.mdelta};
        uls_pkg::ADDR_SCRATCH: nxt_s.rdata = s_ff.scr;
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // Receive FIFO.
    pop = rd && bus_addr == uls_pkg::ADDR_DATA && !dlab && s_ff.rxc != '0;
    push = rxl.done && (s_ff.rxc != cap || pop);
    rx_err = rxl.par_err | rxl.frame_err | rxl.brk;
    if (rxl.done && !push) begin
      nxt_s.oe = 1'b1;
    end
    if (pop) begin
      nxt_s.rxr = s_ff.rxr + 1'b1;
      nxt_s.rxc = nxt_s.rxc - 1'b1;
      if (|s_ff.rxm[s_ff.rxr][10:8]) begin
        nxt_s.rxe = nxt_s.rxe - 1'b1;
      end
    end
    if (push) begin
      nxt_s.rxm[s_ff.rxw] = {rxl.brk, rxl.frame_err, rxl.par_err, rxl.data};
      nxt_s.rxw = s_ff.rxw + 1'b1;
      nxt_s.rxc = nxt_s.rxc + 1'b1;
      nxt_s.rxev = 1'b1;
      if (rx_err) begin
        nxt_s.rxe = nxt_s.rxe + 1'b1;
      end
      if (rx_err && s_ff.fcr_en) begin
        nxt_s.rx_fifo_error_flag = 1'b1;
      end
    end
    // Without the FIFO, errors flag as the character lands; with it, as it reaches the head.
    head_new = pop || (push && s_ff.rxc == '0);
    head = nxt_s.rxm[nxt_s.rxr];
    if (s_ff.fcr_en ? (head_new && nxt_s.rxc != '0) : push) begin
      nxt_s.pe = nxt_s.pe | head[8];
      nxt_s.fe = nxt_s.fe | head[9];
      nxt_s.bi = nxt_s.bi | head[10];
    end
    if (rd && bus_addr == uls_pkg::ADDR_LINE_STATUS && nxt_s.rxe == '0) begin
      nxt_s.rx_fifo_error_flag = 1'b0;
    end

    // Transmit holding FIFO and shifter.
    tx_push = wr && bus_addr == uls_pkg::ADDR_DATA && !dlab && s_ff.txc != cap;
    tx_pop = s_ff.tst == TX_IDLE && s_ff.txc != '0;
    if (tx_push) begin
      nxt_s.txm[s_ff.txw] = bus_wdata;
      nxt_s.txw = s_ff.txw + 1'b1;
      nxt_s.txc = nxt_s.txc + 1'b1;
    end
    if (tx_pop) begin
      nxt_s.tsh = s_ff.txm[s_ff.txr];
      nxt_s.tpar = uls_pkg::uls_par_bit(s_ff.txm[s_ff.txr], s_ff.lcr[1:0], s_ff.lcr[5:4]);
      nxt_s.txr = s_ff.txr + 1'b1;
      nxt_s.txc = nxt_s.txc - 1'b1;
      nxt_s.tst = TX_START;
      nxt_s.tcnt = 4'h0;
    end else if (s_ff.tick && s_ff.tst != TX_IDLE) begin
      nxt_s.tcnt = s_ff.tcnt + 4'h1;
      if (s_ff.tcnt == uls_pkg::TICK_LAST) begin
        case (s_ff.tst)
          TX_START: begin
            nxt_s.tst = TX_DATA;
            nxt_s.tidx = 3'h0;
          end
          TX_DATA: begin
            nxt_s.tsh = s_ff.tsh >> 1;
            nxt_s.tidx = s_ff.tidx + 3'h1;
            if (s_ff.tidx == uls_pkg::MIN_LAST_BIT + {1'b0, s_ff.lcr[1:0]}) begin
              nxt_s.tst = s_ff.lcr[uls_pkg::LCR_PAR_EN] ? TX_PAR : TX_STOP;
              nxt_s.tidx = 3'h0;
            end
          end
          TX_PAR: nxt_s.tst = TX_STOP;
          TX_STOP: begin
            if (s_ff.lcr[uls_pkg::LCR_STOP2] && s_ff.tidx == 3'h0) begin
              nxt_s.tidx = 3'h1;
            end else begin
              nxt_s.tst = TX_IDLE;
            end
          end
          default: nxt_s.tst = TX_IDLE;
        endcase
      end
    end

    // Register writes.
    if (wr) begin
      case (bus_addr)
        uls_pkg::ADDR_DATA: begin
          if (dlab) begin
            nxt_s.dll = bus_wdata;
            nxt_s.bcnt = 16'h0000;
          end
        end
        uls_pkg::ADDR_DIV_HIGH: begin
          if (dlab) begin
            nxt_s.dlm = bus_wdata;
            nxt_s.bcnt = 16'h0000;
          end
        end
        uls_pkg::ADDR_FIFO_CTRL: begin
          nxt_s.fcr_en = bus_wdata[uls_pkg::FCR_EN];
          if (bus_wdata[uls_pkg::FCR_RX_RST] || bus_wdata[uls_pkg::FCR_EN] != s_ff.fcr_en) begin
            nxt_s.rxw = '0;
            nxt_s.rxr = '0;
            nxt_s.rxc = '0;
            nxt_s.rxe = '0;
          end
          if (bus_wdata[uls_pkg::FCR_TX_RST] || bus_wdata[uls_pkg::FCR_EN] != s_ff.fcr_en) begin
            nxt_s.txw = '0;
            nxt_s.txr = '0;
            nxt_s.txc = '0;
          end
        end
        uls_pkg::ADDR_LINE_CTRL: nxt_s.lcr = bus_wdata;
        uls_pkg::ADDR_MODEM_CTRL: nxt_s.mcr = bus_wdata[4:0];
        uls_pkg::ADDR_SCRATCH: nxt_s.scr = bus_wdata;
        default: nxt_s.scr = s_ff.scr;
      endcase
    end

    nxt_s.txev = s_ff.txc != '0 && nxt_s.txc == '0;
    case (nxt_s.tst)
      TX_START: nxt_s.tout = 1'b0;
      TX_DATA: nxt_s.tout = nxt_s.tsh[0];
      TX_PAR: nxt_s.tout = nxt_s.tpar;
      default: nxt_s.tout = 1'b1;
    endcase
    if (nxt_s.lcr[uls_pkg::LCR_BREAK]) begin
      nxt_s.tout = 1'b0;
    end
    nxt_s.sout = nxt_s.mcr[uls_pkg::MCR_LOOP] ? 1'b1 : nxt_s.tout;
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_ff <= '0;
      s_ff.sin_sync <= 3'h7;
      s_ff.sin_f <= 1'b1;
      s_ff.msy1 <= 4'hF;
      s_ff.msy2 <= 4'hF;
      s_ff.msy3 <= 4'hF;
      s_ff.mpin <= 4'hF;
      s_ff.lcr <= uls_pkg::LCR_RESET;
      s_ff.mcr <= uls_pkg::MCR_RESET;
      s_ff.dll <= uls_pkg::DLL_RESET;
      s_ff.dlm <= uls_pkg::DLM_RESET;
      s_ff.scr <= uls_pkg::SCR_RESET;
      s_ff.tst <= TX_IDLE;
      s_ff.tout <= 1'b1;
      s_ff.sout <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs and receiver link; modem inputs reach no transfer logic.
  assign rxl.tick = s_ff.tick;
  assign rxl.sin = s_ff.mcr[uls_pkg::MCR_LOOP] ? s_ff.tout : s_ff.sin_f;
  assign rxl.word_len = s_ff.lcr[1:0];
  assign rxl.par_en = s_ff.lcr[uls_pkg::LCR_PAR_EN];
  assign rxl.par_sel = s_ff.lcr[5:4];
  assign bus_rdata = s_ff.rdata;
  assign bus_ack = s_ff.ack;
  assign serial_out_pin = s_ff.sout;
  assign dtr_n_pin = ~(s_ff.mcr[uls_pkg::MCR_DTR] & ~s_ff.mcr[uls_pkg::MCR_LOOP]);
  assign rts_n_pin = ~(s_ff.mcr[uls_pkg::MCR_RTS] & ~s_ff.mcr[uls_pkg::MCR_LOOP]);
  assign rx_event_pulse = s_ff.rxev;
  assign tx_event_pulse = s_ff.txev;
  assign modem_event_pulse = s_ff.mev;
endmodule

// *** verif/uls_chk.sv ***
// Port-level assertions for the serial port status block.
`timescale 1ns/10ps
module uls_chk (
  input wire logic clk_sys, // Clock.
  input wire logic reset, // Reset.
  input wire logic bus_req, // Strobe.
  input wire logic bus_write, // Write.
  input wire logic [31:0] bus_addr, // Address.
  input wire logic [7:0] bus_wdata, // Data in.
  input wire logic bus_ack, // Done.
  input wire logic serial_out_pin, // Line out.
  input wire logic cts_n_pin, // Clear to send.
  input wire logic dtr_n_pin, // Ready out.
  input wire logic rts_n_pin, // Request out.
  input wire logic rx_event_pulse, // Rx event.
  input wire logic tx_event_pulse, // Tx event.
  input wire logic modem_event_pulse // Modem event.
);
  logic loop_ff;
  // Follows the loopback bit as the host writes it.
  always_ff @(posedge clk_sys or posedge reset)
    if (reset) loop_ff <= 1'b0;
    else if (bus_req && bus_write && bus_addr == uls_pkg::ADDR_MODEM_CTRL) loop_ff <= bus_wdata[4];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_ack_next: assert property (bus_req |=> bus_ack) else $error("no ack");
  chk_loop_mark: assert property (loop_ff && $past(loop_ff, 2) |-> serial_out_pin) else $error("no mark");
  chk_loop_outs: assert property (loop_ff |-> dtr_n_pin && rts_n_pin) else $error("outs active");
  chk_rx_pulse: assert property (rx_event_pulse |=> !rx_event_pulse) else $error("rx pulse");
  chk_tx_pulse: assert property (tx_event_pulse |=> !tx_event_pulse) else $error("tx pulse");
  chk_mdm_pulse: assert property (modem_event_pulse |=> !modem_event_pulse) else $error("mdm pulse");
  chk_cts_delta: assert property (!loop_ff && $changed(cts_n_pin) |-> ##[1:10] modem_event_pulse)
    else $error("no modem event");
  chk_start_len: assert property (!loop_ff && $fell(serial_out_pin) |-> !serial_out_pin [*8])
    else $error("start short");
endmodule
bind uls_uart_status uls_chk chk (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .bus_write(bus_write),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .serial_out_pin(serial_out_pin),
  .cts_n_pin(cts_n_pin), .dtr_n_pin(dtr_n_pin), .rts_n_pin(rts_n_pin), .rx_event_pulse(rx_event_pulse),
  .tx_event_pulse(tx_event_pulse), .modem_event_pulse(modem_event_pulse));

// *** verif/uls_line_model.sv ***
// Far end of the serial line and the modem handshake inputs.
`timescale 1ns/10ps
module uls_line_model #(
  parameter int BIT_CYC = 16 // Clocks per bit at divisor one.
) (
  input wire logic clk_sys, // Clock.
  output logic rx_line, // Serial data, marks when idle.
  output logic [3:0] mdm_n // Carrier, ring, set ready, clear to send.
);
  initial begin
    rx_line = 1'b1;
    mdm_n = 4'hF;
  end
  // Sends n bits LSB first, then marks.
  task automatic frame(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_line <= b[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask
  task automatic pins(input logic [3:0] v);
    @(posedge clk_sys);
    mdm_n <= v;
  endtask
endmodule

// *** verif/uls_uart_status_bench.sv ***
// Self-checking bench for the serial port status block.
`timescale 1ns/10ps
module uls_uart_status_bench;
  localparam logic [31:0] DT = uls_pkg::ADDR_DATA;
  localparam logic [31:0] LS = uls_pkg::ADDR_LINE_STATUS;
  localparam logic [31:0] MS = uls_pkg::ADDR_MODEM_STATUS;
  localparam logic [31:0] SC = uls_pkg::ADDR_SCRATCH;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic bus_req = 1'b0;
  logic bus_write = 1'b0;
  logic [31:0] bus_addr = 32'h0000_0000;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic bus_ack, sin, sout, dtr_n, rts_n, rx_p, tx_p, md_p;
  logic [3:0] mdm_n;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  uls_line_model line (.clk_sys(clk_sys), .rx_line(sin), .mdm_n(mdm_n));
  uls_uart_status uut (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .serial_in_pin(sin), .serial_out_pin(sout), .cts_n_pin(mdm_n[0]), .dsr_n_pin(mdm_n[1]),
    .ri_n_pin(mdm_n[2]), .dcd_n_pin(mdm_n[3]), .dtr_n_pin(dtr_n), .rts_n_pin(rts_n),
    .rx_event_pulse(rx_p), .tx_event_pulse(tx_p), .modem_event_pulse(md_p));
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] q, input logic [15:0] e);
    total_checks++;
    if (q !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, q, e);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    bus_req <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_req <= 1'b0;
    @(posedge clk_sys);
    q = bus_rdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    cmp({8'h00, q}, {8'h00, e});
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic t_regs();
    rd(LS, 8'h60);
    rd(MS, 8'h00);
    rd(SC, 8'h00);
    wr(SC, 8'hA5);
    rd(SC, 8'hA5);
    rd(LS, 8'h60);
  endtask
  // Sends k copies of a frame, then reads status, data and status again.
  task automatic t_rx(input logic [7:0] lc, input logic [11:0] b, input int n, input int k,
    input logic [7:0] ls, input logic [7:0] dv);
    wr(uls_pkg::ADDR_LINE_CTRL, lc);
    repeat (k) line.frame(b, n);
    repeat (200) @(posedge clk_sys);
    rd(LS, ls);
    rd(DT, dv);
    rd(LS, {ls[7], 7'h60});
  endtask
  task automatic t_tx();
    logic [9:0] cap;
    int k;
    wr(uls_pkg::ADDR_LINE_CTRL, 8'h03);
    wr(DT, 8'h3C);
    k = 0;
    while (sout !== 1'b0 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    rd(LS, 8'h20);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      cap[i] = sout;
      repeat (16) @(posedge clk_sys);
    end
    cmp({6'h00, cap}, 16'h0278);
    rd(LS, 8'h60);
  endtask
  task automatic t_modem();
    line.pins(4'b1110);
    repeat (10) @(posedge clk_sys);
    rd(MS, 8'h11);
    rd(MS, 8'h10);
    line.pins(4'b1010);
    repeat (10) @(posedge clk_sys);
    rd(MS, 8'h50);
    line.pins(4'b1111);
    repeat (10) @(posedge clk_sys);
    rd(MS, 8'h05);
    wr(uls_pkg::ADDR_MODEM_CTRL, 8'h12);
    repeat (4) @(posedge clk_sys);
    rd(MS, 8'h11);
    wr(DT, 8'h96);
    repeat (220) @(posedge clk_sys);
    rd(DT, 8'h96);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_rx(8'h03, {3'b001, 8'h5A, 1'b0}, 10, 1, 8'h61, 8'h5A);
    t_rx(8'h03, {3'b001, 8'h5A, 1'b0}, 10, 2, 8'h63, 8'h5A);
    t_rx(8'h0B, {3'b011, 8'h01, 1'b0}, 11, 1, 8'h65, 8'h01);
    t_rx(8'h03, {3'b000, 8'h5A, 1'b0}, 10, 1, 8'h6B, 8'h5A);
    t_rx(8'h03, 12'h000, 12, 1, 8'h79, 8'h00);
    wr(uls_pkg::ADDR_FIFO_CTRL, 8'h01);
    t_rx(8'h0B, {3'b011, 8'h01, 1'b0}, 11, 1, 8'hE5, 8'h01);
    rd(LS, 8'h60);
    t_tx();
    t_modem();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
endmodule
